// >>> verilog/input_calibration_sequencer.sv
/*
 * Two-point calibration sequencer for two analog inputs and one frequency
 * input, with percent scaling and line/roll speed input mapping, behind an
 * AHB-Lite register slave. Assumes ADC counts that hold steady for several
 * clocks per conversion, a debounced confirm key and a 20 MHz hclk.
 */
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`include "cal_cfg.svh"

module input_calibration_sequencer
  import cal_pkg::*;
#(
  parameter int unsigned PROMPT_CYCLES    = `PROMPT_CYCLES,
  parameter int unsigned FREQ_GATE_CYCLES = `FREQ_GATE_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic [31:0] hrdata,
  output      logic        hresp,
  // Sensor pins
  input  wire logic [11:0] ain1_count,
  input  wire logic [11:0] ain2_count,
  input  wire logic        freq_pulse,
  input  wire logic        confirm_key,
  // Operator display
  output      disp_mode_t  display_mode,
  output      logic [15:0] display_value,
  // Scaled results
  output      logic [15:0] line_speed_pct,
  output      logic [15:0] tension_setpoint_pct,
  output      logic [15:0] diameter_signal_pct,
  output      logic [15:0] diameter_value,
  output      logic [15:0] roll_speed_pct,
  // Interrupt
  output      logic        irq
);

  // a + (b - a) * p / 100.00 %, used for bias/gain and diameter value
  function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] p);
    logic signed [47:0] prod;
    logic signed [47:0] res;
    prod = ($signed({32'h0, b}) - $signed({32'h0, a})) * $signed({32'h0, p});
    res  = $signed({32'h0, a}) + prod / $signed(48'(`PCT_FULL));
    if (res < 0) begin
      lerp = 16'h0000;
    end else begin
      lerp = res[15:0];
    end
  endfunction

  // Two-flop synchronisers for every pin
  logic [11:0] ain1_s1_q, ain1_s2_q, ain2_s1_q, ain2_s2_q;
  logic [2:0]  freq_sync_q;
  logic [2:0]  key_sync_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ain1_s1_q   <= 12'h000;
      ain1_s2_q   <= 12'h000;
      ain2_s1_q   <= 12'h000;
      ain2_s2_q   <= 12'h000;
      freq_sync_q <= 3'h0;
      key_sync_q  <= 3'h0;
    end else begin
      ain1_s1_q   <= ain1_count;
      ain1_s2_q   <= ain1_s1_q;
      ain2_s1_q   <= ain2_count;
      ain2_s2_q   <= ain2_s1_q;
      freq_sync_q <= {freq_sync_q[1:0], freq_pulse};
      key_sync_q  <= {key_sync_q[1:0], confirm_key};
    end
  end

  logic confirm;
  logic freq_edge;
  assign confirm   = key_sync_q[1] & ~key_sync_q[2];
  assign freq_edge = freq_sync_q[1] & ~freq_sync_q[2];

  // Frequency meter: edges counted over a gate, so one count per hertz
  logic [31:0] gate_cnt_q;
  logic [15:0] edge_cnt_q;
  logic [15:0] freq_hz_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_cnt_q <= 32'h0000_0000;
      edge_cnt_q <= 16'h0000;
      freq_hz_q  <= 16'h0000;
    end else if (gate_cnt_q == FREQ_GATE_CYCLES - 1) begin
      gate_cnt_q <= 32'h0000_0000;
      edge_cnt_q <= {15'h0000, freq_edge};
      freq_hz_q  <= edge_cnt_q;
    end else begin
      gate_cnt_q <= gate_cnt_q + 32'h0000_0001;
      if (freq_edge && edge_cnt_q != 16'hFFFF) begin
        edge_cnt_q <= edge_cnt_q + 16'h0001; // Saturates rather than wraps
      end
    end
  end

  // Raw readings per channel
  logic [15:0] raw [3];
  assign raw[CH_AIN1] = {4'h0, ain1_s2_q};
  assign raw[CH_AIN2] = {4'h0, ain2_s2_q};
  assign raw[CH_FREQ] = freq_hz_q;

  // AHB-Lite bus state
  logic        wr_pend_q, rd_pend_q, hreadyout_q;
  logic [7:0]  addr_q;
  logic [31:0] hrdata_q;
  logic        addr_phase;
  logic        wr_en;
  assign addr_phase = hsel & htrans[1] & hready;
  assign wr_en      = wr_pend_q;

  // Software registers
  logic [7:0]  method_q;
  logic [15:0] bias_q, gain_q, core_q, maxd_q, tfix_q;
  logic [1:0]  irq_stat_q, irq_mask_q;
  logic [2:0]  trig;
  assign trig = (wr_en && addr_q == `OFS_CTRL) ? hwdata[2:0] : 3'h0;

  // Percent writes saturate at full scale
  function automatic logic [15:0] pct_sat(input logic [31:0] v);
    pct_sat = (v > 32'(`PCT_FULL)) ? `PCT_FULL : v[15:0];
  endfunction

  // Configuration writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      method_q   <= `RST_METHOD;
      bias_q     <= `RST_BIAS;
      gain_q     <= `RST_GAIN;
      core_q     <= `RST_CORE_DIA;
      maxd_q     <= `RST_MAX_DIA;
      tfix_q     <= 16'h0000;
      irq_mask_q <= 2'h0;
    end else if (wr_en) begin
      unique case (addr_q)
        `OFS_METHOD:      method_q   <= hwdata[7:0];
        `OFS_AIN2_BIAS:   bias_q     <= pct_sat(hwdata);
        `OFS_AIN2_GAIN:   gain_q     <= pct_sat(hwdata);
        `OFS_CORE_DIA:    core_q     <= hwdata[15:0];
        `OFS_MAX_DIA:     maxd_q     <= hwdata[15:0];
        `OFS_TENSION_FIX: tfix_q     <= pct_sat(hwdata);
        `OFS_IRQ_MASK:    irq_mask_q <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // Calibration sequence
  seq_state_t  state_q;
  cal_ch_t     ch_q;
  logic [31:0] tmr_q;
  logic [15:0] cand_lo_q;
  logic [15:0] cal_lo_q [3];
  logic [15:0] cal_hi_q [3];
  logic        ev_done, ev_fault;
  logic        tmr_end;
  assign tmr_end = (tmr_q == PROMPT_CYCLES - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= ST_IDLE;
      ch_q      <= CH_AIN1;
      tmr_q     <= 32'h0000_0000;
      cand_lo_q <= 16'h0000;
      ev_done   <= 1'b0;
      ev_fault  <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        cal_lo_q[i] <= `RST_CAL_LO;
        cal_hi_q[i] <= `RST_CAL_HI;
      end
    end else begin
      ev_done  <= 1'b0;
      ev_fault <= 1'b0;
      tmr_q    <= tmr_end ? tmr_q : tmr_q + 32'h0000_0001;
      unique case (state_q)
        ST_IDLE, ST_FAULT: begin
          // Lowest bit wins when several triggers are written together
          if (trig[`CTRL_AIN1_BIT]) begin
            ch_q    <= CH_AIN1;
            state_q <= ST_LO_PROMPT;
            tmr_q   <= 32'h0000_0000;
          end else if (trig[`CTRL_AIN2_BIT]) begin
            ch_q    <= CH_AIN2;
            state_q <= ST_LO_PROMPT;
            tmr_q   <= 32'h0000_0000;
          end else if (trig[`CTRL_FREQ_BIT]) begin
            ch_q    <= CH_FREQ;
            state_q <= ST_LO_PROMPT;
            tmr_q   <= 32'h0000_0000;
          end
        end
        ST_LO_PROMPT: begin
          if (tmr_end) begin
            state_q <= ST_LO_RAW;
          end
        end
        ST_LO_RAW: begin
          if (confirm) begin
            cand_lo_q <= raw[ch_q];
            state_q   <= ST_HI_PROMPT;
            tmr_q     <= 32'h0000_0000;
          end
        end
        ST_HI_PROMPT: begin
          if (tmr_end) begin
            state_q <= ST_HI_RAW;
          end
        end
        ST_HI_RAW: begin
          if (confirm) begin
            if (cand_lo_q > raw[ch_q]) begin
              state_q  <= ST_FAULT; // Old points stay
              ev_fault <= 1'b1;
            end else begin
              cal_lo_q[ch_q] <= cand_lo_q;
              cal_hi_q[ch_q] <= raw[ch_q];
              state_q        <= ST_IDLE;
              ev_done        <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Display follows the sequence; raw is hertz on the frequency channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      display_mode  <= DISP_NONE;
      display_value <= 16'h0000;
    end else begin
      display_value <= raw[ch_q];
      unique case (state_q)
        ST_LO_PROMPT:         display_mode <= DISP_LOW_CAL;
        ST_HI_PROMPT:         display_mode <= DISP_HIGH_CAL;
        ST_LO_RAW, ST_HI_RAW: display_mode <= DISP_RAW;
        ST_FAULT:             display_mode <= DISP_CAL_FAULT;
        default:              display_mode <= DISP_NONE;
      endcase
    end
  end

  // Per-channel scaling, clamped inside the scaler
  logic [15:0] pct [3];
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_scale
      pct_scaler u_scale (
        .reading (raw[g]),
        .cal_lo  (cal_lo_q[g]),
        .cal_hi  (cal_hi_q[g]),
        .pct     (pct[g])
      );
    end
  endgenerate

  // Input mapping by method selector
  logic [15:0] dia_pct;
  assign dia_pct = lerp(bias_q, gain_q, pct[CH_AIN2]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_speed_pct       <= 16'h0000;
      tension_setpoint_pct <= 16'h0000;
      roll_speed_pct       <= 16'h0000;
      diameter_signal_pct  <= 16'h0000;
      diameter_value       <= 16'h0000;
    end else begin
      diameter_signal_pct <= dia_pct;
      diameter_value      <= lerp(core_q, maxd_q, dia_pct);
      tension_setpoint_pct <= (method_q >= `METHOD_TORQUE_MIN) ? pct[CH_AIN1]
                                                               : 16'h0000;
      unique case (method_q)
        `METHOD_LRS_A: begin
          line_speed_pct <= pct[CH_FREQ];
          roll_speed_pct <= pct[CH_AIN2];
        end
        `METHOD_LRS_B: begin
          line_speed_pct <= pct[CH_AIN2];
          roll_speed_pct <= pct[CH_FREQ];
        end
        `METHOD_LRS_C: begin
          // Both analog inputs are speeds, so tension is the fixed setting
          line_speed_pct       <= pct[CH_AIN1];
          roll_speed_pct       <= pct[CH_AIN2];
          tension_setpoint_pct <= tfix_q;
        end
        default: begin
          line_speed_pct <= pct[CH_AIN1];
          roll_speed_pct <= 16'h0000;
        end
      endcase
    end
  end

  // Sticky interrupt status, write one to clear; a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= 2'h0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_en && addr_q == `OFS_IRQ_STATUS) ? hwdata[1:0] : 2'h0))
                    | {ev_fault, ev_done};
      irq        <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read decode
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    unique case (a)
      `OFS_METHOD:      rd_mux = {24'h0, method_q};
      `OFS_AIN2_BIAS:   rd_mux = {16'h0, bias_q};
      `OFS_AIN2_GAIN:   rd_mux = {16'h0, gain_q};
      `OFS_CORE_DIA:    rd_mux = {16'h0, core_q};
      `OFS_MAX_DIA:     rd_mux = {16'h0, maxd_q};
      `OFS_TENSION_FIX: rd_mux = {16'h0, tfix_q};
      `OFS_SEQ_STATUS:  rd_mux = {6'h0, ch_q, 2'h0, state_q, display_value};
      `OFS_LINE_PCT:    rd_mux = {16'h0, line_speed_pct};
      `OFS_TENSION_PCT: rd_mux = {16'h0, tension_setpoint_pct};
      `OFS_DIA_PCT:     rd_mux = {16'h0, diameter_signal_pct};
      `OFS_DIA_VALUE:   rd_mux = {16'h0, diameter_value};
      `OFS_ROLL_PCT:    rd_mux = {16'h0, roll_speed_pct};
      `OFS_IRQ_STATUS:  rd_mux = {30'h0, irq_stat_q};
      `OFS_IRQ_MASK:    rd_mux = {30'h0, irq_mask_q};
      `OFS_CAL_AIN1:    rd_mux = {cal_hi_q[CH_AIN1], cal_lo_q[CH_AIN1]};
      `OFS_CAL_AIN2:    rd_mux = {cal_hi_q[CH_AIN2], cal_lo_q[CH_AIN2]};
      `OFS_CAL_FREQ:    rd_mux = {cal_hi_q[CH_FREQ], cal_lo_q[CH_FREQ]};
      default:          rd_mux = 32'h0000_0000; // CTRL and unmapped read zero
    endcase
  endfunction

  // Bus slave: writes take no wait, reads one wait so a write just ahead lands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      hreadyout_q <= 1'b1;
      addr_q      <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_phase & hwrite;
      rd_pend_q <= addr_phase & ~hwrite;
      if (addr_phase) begin
        addr_q <= {haddr[7:2], 2'b00};
      end
      hreadyout_q <= ~(addr_phase & ~hwrite);
      if (rd_pend_q) begin
        hrdata_q <= rd_mux(addr_q);
      end
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = 1'b0; // Always OKAY, driven constant

endmodule

// >>> verilog/cal_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the input
 * calibration sequencer. Assumes a 20 MHz system clock and a word-aligned
 * AHB-Lite register map.
 */
`ifndef CAL_CFG_SVH
`define CAL_CFG_SVH

// Clock and times
`define CLK_HZ            20000000
`define PROMPT_TIME_MS    500
`define FREQ_GATE_MS      1000
`define PROMPT_CYCLES     (`PROMPT_TIME_MS * (`CLK_HZ / 1000))
`define FREQ_GATE_CYCLES  (`FREQ_GATE_MS * (`CLK_HZ / 1000))

// Register byte offsets
`define OFS_CTRL          8'h00
`define OFS_METHOD        8'h04
`define OFS_AIN2_BIAS     8'h08
`define OFS_AIN2_GAIN     8'h0C
`define OFS_CORE_DIA      8'h10
`define OFS_MAX_DIA       8'h14
`define OFS_TENSION_FIX   8'h18
`define OFS_SEQ_STATUS    8'h1C
`define OFS_LINE_PCT      8'h20
`define OFS_TENSION_PCT   8'h24
`define OFS_DIA_PCT       8'h28
`define OFS_DIA_VALUE     8'h2C
`define OFS_ROLL_PCT      8'h30
`define OFS_IRQ_STATUS    8'h34
`define OFS_IRQ_MASK      8'h38
`define OFS_CAL_AIN1      8'h3C
`define OFS_CAL_AIN2      8'h40
`define OFS_CAL_FREQ      8'h44

// Control bit positions
`define CTRL_AIN1_BIT     0
`define CTRL_AIN2_BIT     1
`define CTRL_FREQ_BIT     2

// Interrupt bit positions
`define IRQ_DONE_BIT      0
`define IRQ_FAULT_BIT     1

// Percent scale: 100.00 % is 10000 counts
`define PCT_FULL          16'h2710

// Method selector codes
`define METHOD_TORQUE_MIN 8'h05
`define METHOD_LRS_A      8'h08
`define METHOD_LRS_B      8'h09
`define METHOD_LRS_C      8'h0A

// Reset values
`define RST_METHOD        8'h01
`define RST_BIAS          16'h0000
`define RST_GAIN          16'h2710
`define RST_CORE_DIA      16'h0064
`define RST_MAX_DIA       16'h03E8
`define RST_CAL_LO        16'h0000
`define RST_CAL_HI        16'h0FFF

`endif

// >>> verilog/cal_pkg.sv
/*
 * Types of the input calibration sequencer: sequence states, display
 * modes and input channels. Assumes nothing of its surroundings.
 */
package cal_pkg;

  // Sequence states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE      = 6'b000001,
    ST_LO_PROMPT = 6'b000010,
    ST_LO_RAW    = 6'b000100,
    ST_HI_PROMPT = 6'b001000,
    ST_HI_RAW    = 6'b010000,
    ST_FAULT     = 6'b100000
  } seq_state_t;

  // What the operator display shows
  typedef enum logic [2:0] {
    DISP_NONE      = 3'h0,
    DISP_LOW_CAL   = 3'h1,
    DISP_HIGH_CAL  = 3'h2,
    DISP_RAW       = 3'h3,
    DISP_CAL_FAULT = 3'h4
  } disp_mode_t;

  // Calibrated inputs
  typedef enum logic [1:0] {
    CH_AIN1 = 2'h0,
    CH_AIN2 = 2'h1,
    CH_FREQ = 2'h2
  } cal_ch_t;

endpackage

// >>> verilog/pct_scaler.sv
/*
 * Two-point linear scaler: maps a reading onto 0 .. 100.00 % between a
 * low and a high calibration point. Purely combinational; the caller
 * registers the result.
 */
`timescale 1ns/1ns
`include "cal_cfg.svh"

module pct_scaler (
  // Reading and calibration points
  input  wire logic [15:0] reading,
  input  wire logic [15:0] cal_lo,
  input  wire logic [15:0] cal_hi,
  // Scaled result in 0.01 % steps
  output      logic [15:0] pct
);

  logic [31:0] num;
  logic [15:0] den;
  logic [31:0] quo;

  // Denominator never zero: when lo equals hi the clamps decide instead
  assign den = (cal_hi > cal_lo) ? (cal_hi - cal_lo) : 16'h0001;
  assign num = 32'(reading - cal_lo) * 32'(`PCT_FULL);
  assign quo = num / 32'(den);

  // Readings outside the points are clamped
  always_comb begin
    if (reading <= cal_lo) begin
      pct = 16'h0000;
    end else if (reading >= cal_hi) begin
      pct = `PCT_FULL;
    end else begin
      pct = quo[15:0];
    end
  end

endmodule

// >>> testbench/cal_seq_monitor.sv
/* Checker for the input calibration sequencer top ports.
   Assumes it is bound into the design and PROMPT_CYCLES stays under 30. */
`timescale 1ns/1ns
module cal_seq_monitor
  import cal_pkg::*;
#(
  parameter int unsigned PROMPT_CYCLES = 8
) (
  // Clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Display and results
  input wire disp_mode_t  display_mode,
  input wire logic [15:0] line_speed_pct,
  input wire logic [15:0] tension_setpoint_pct,
  input wire logic [15:0] diameter_signal_pct,
  input wire logic [15:0] roll_speed_pct
);
  logic [7:0] prompt_cnt_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Counts prompt cycles, since a stuck prompt would never show at the ports otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      prompt_cnt_q <= 8'h00;
    else if (display_mode inside {DISP_LOW_CAL, DISP_HIGH_CAL})
      prompt_cnt_q <= prompt_cnt_q + 8'h01;
    else
      prompt_cnt_q <= 8'h00;
  end

  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not OKAY");

  property p_rd_wait;
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

  property p_clamp;
    line_speed_pct <= 16'h2710 && tension_setpoint_pct <= 16'h2710 &&
    diameter_signal_pct <= 16'h2710 && roll_speed_pct <= 16'h2710;
  endproperty
  a_clamp: assert property (p_clamp) else $error("percent above full scale");

  property p_lo_to_raw;
    display_mode == DISP_LOW_CAL |-> ##[1:40] display_mode == DISP_RAW;
  endproperty
  a_lo_to_raw: assert property (p_lo_to_raw) else $error("low prompt stuck");

  property p_hi_to_raw;
    display_mode == DISP_HIGH_CAL |-> ##[1:40] display_mode == DISP_RAW;
  endproperty
  a_hi_to_raw: assert property (p_hi_to_raw) else $error("high prompt stuck");

  property p_hi_after_raw;
    $changed(display_mode) && display_mode == DISP_HIGH_CAL |-> $past(display_mode) == DISP_RAW;
  endproperty
  a_hi_after_raw: assert property (p_hi_after_raw) else $error("high prompt early");

  property p_fault_from_raw;
    $rose(display_mode == DISP_CAL_FAULT) |-> $past(display_mode) == DISP_RAW;
  endproperty
  a_fault_from_raw: assert property (p_fault_from_raw) else $error("fault early");

  property p_fault_holds;
    display_mode == DISP_CAL_FAULT |=> display_mode inside {DISP_CAL_FAULT, DISP_LOW_CAL};
  endproperty
  a_fault_holds: assert property (p_fault_holds) else $error("fault cleared");

  property p_start_idle;
    $changed(display_mode) && display_mode == DISP_LOW_CAL
      |-> $past(display_mode) inside {DISP_NONE, DISP_CAL_FAULT};
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("restart mid-run");

  property p_prompt_len;
    int'(prompt_cnt_q) <= PROMPT_CYCLES + 2;
  endproperty
  a_prompt_len: assert property (p_prompt_len) else $error("prompt too long");
endmodule

// >>> testbench/sensor_panel_model.sv
/* Operator keypad, pots and pulse source in front of the sequencer.
   Assumes the bench sets levels and requests key presses. */
`timescale 1ns/1ns
module sensor_panel_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Levels from the bench
  input  wire logic [11:0] ain1_level,
  input  wire logic [11:0] ain2_level,
  input  wire logic [3:0]  pulse_half,
  input  wire logic        press,
  // Pins toward the sequencer
  output      logic [11:0] ain1_count,
  output      logic [11:0] ain2_count,
  output      logic        freq_pulse,
  output      logic        confirm_key
);
  logic [3:0] half_cnt_q;
  logic [2:0] key_cnt_q;

  // Converter counts; levels hold far longer than the input synchroniser needs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ain1_count <= 12'h000;
      ain2_count <= 12'h000;
    end else begin
      ain1_count <= ain1_level;
      ain2_count <= ain2_level;
    end
  end

  // Pulse source; stands low while stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_pulse <= 1'b0;
      half_cnt_q <= 4'h0;
    end else if (pulse_half == 4'h0) begin
      freq_pulse <= 1'b0;
      half_cnt_q <= 4'h0;
    end else if (half_cnt_q + 4'h1 >= pulse_half) begin
      freq_pulse <= !freq_pulse;
      half_cnt_q <= 4'h0;
    end else
      half_cnt_q <= half_cnt_q + 4'h1;
  end

  // Key held six clocks so the synchroniser edge detect sees one clean press
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      key_cnt_q <= 3'h0;
    else if (press)
      key_cnt_q <= 3'h6;
    else if (key_cnt_q != 3'h0)
      key_cnt_q <= key_cnt_q - 3'h1;
  end
  assign confirm_key = (key_cnt_q != 3'h0);
endmodule

// >>> testbench/test_input_calibration_sequencer.sv
/* Bench for the calibration sequencer: AHB-Lite tasks, operator sequences
   and scaled output checks. Assumes the sensor panel model and checker. */
`timescale 1ns/1ns
module test_input_calibration_sequencer;
  import cal_pkg::*;
  // Bench signals
  logic             hclk, hresetn, hsel, hwrite, press, rdy;
  logic [1:0]       htrans;
  logic [7:0]       haddr;
  logic [31:0]      hwdata, rdat, rd;
  logic [11:0]      ain1_level, ain2_level;
  logic [3:0]       pulse_half;
  wire logic        hreadyout, hresp, irq, freq_pulse, confirm_key;
  wire logic [11:0] ain1_count, ain2_count;
  wire logic [31:0] hrdata;
  wire disp_mode_t  display_mode;
  wire logic [15:0] display_value, line_speed_pct, tension_setpoint_pct;
  wire logic [15:0] diameter_signal_pct, diameter_value, roll_speed_pct;
  int               errors, compares;
  logic [7:0]       ra [7] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h3C, 8'h80};
  logic [31:0]      re [7] = '{32'h0, 32'h1, 32'h2710, 32'h64, 32'h3E8, 32'h0FFF0000, 32'h0};

  input_calibration_sequencer #(.PROMPT_CYCLES(8), .FREQ_GATE_CYCLES(100))
    input_calibration_sequencer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ain1_count(ain1_count),
    .ain2_count(ain2_count), .freq_pulse(freq_pulse), .confirm_key(confirm_key),
    .display_mode(display_mode), .display_value(display_value),
    .line_speed_pct(line_speed_pct), .tension_setpoint_pct(tension_setpoint_pct),
    .diameter_signal_pct(diameter_signal_pct), .diameter_value(diameter_value),
    .roll_speed_pct(roll_speed_pct), .irq(irq));
  sensor_panel_model sensor_panel_model_i (
    .hclk(hclk), .hresetn(hresetn), .ain1_level(ain1_level), .ain2_level(ain2_level),
    .pulse_half(pulse_half), .press(press), .ain1_count(ain1_count),
    .ain2_count(ain2_count), .freq_pulse(freq_pulse), .confirm_key(confirm_key));

  // Clock, and mid-cycle copies so edge sampling never races the slave flops
  always #25 hclk = ~hclk;
  always @(negedge hclk) begin
    rdy <= hreadyout;
    rdat <= hrdata;
  end

  task automatic summarize();
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single transfer; waits on hready with no assumed latency
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (rdy !== 1'b1);
    rd = rdat;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic look(input int n);
    repeat (n) @(negedge hclk);
  endtask
  task automatic wait_mode(input disp_mode_t m);
    for (int i = 0; i < 2000 && display_mode !== m; i++) @(negedge hclk);
    chk(display_mode, m);
  endtask
  task automatic lvl(input int b, input logic [11:0] v);
    @(posedge hclk);
    case (b)
      0: ain1_level <= v;
      1: ain2_level <= v;
      default: pulse_half <= v[3:0];
    endcase
  endtask
  task automatic key();
    @(posedge hclk);
    press <= 1'b1;
    @(posedge hclk);
    press <= 1'b0;
  endtask
  // Full two-point sequence; frequency levels are pulse half periods
  task automatic cal(input int b, input logic [11:0] lo, input logic [11:0] hi,
                     input disp_mode_t fin);
    lvl(b, lo);
    wr(8'h00, 32'h1 << b);
    wait_mode(DISP_RAW);
    look(300);
    chk(display_value, {4'h0, lo});
    key();
    wait_mode(DISP_HIGH_CAL);
    wait_mode(DISP_RAW);
    lvl(b, hi);
    look(300);
    key();
    wait_mode(fin);
  endtask

  // Hang guard, far beyond the expected run of some 3000 cycles
  initial begin
    repeat (60000) @(posedge hclk);
    errors++;
    summarize();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 8'h00;
    hwdata = 32'h0;
    press = 1'b0;
    ain1_level = 12'h000;
    ain2_level = 12'h000;
    pulse_half = 4'h0;
    errors = 0;
    compares = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, write-only control and an unmapped word read as zero
    for (int i = 0; i < 7; i++) rdc(ra[i], re[i]);
    wr(8'h38, 32'h3);
    cal(0, 12'h100, 12'h900, DISP_NONE);
    rdc(8'h3C, 32'h09000100);
    rdc(8'h34, 32'h1);
    chk(irq, 1'b1);
    wr(8'h34, 32'h1);
    lvl(0, 12'h500);
    look(10);
    chk(irq, 1'b0);
    chk(line_speed_pct, 16'h1388);
    lvl(0, 12'h050);
    look(10);
    chk(line_speed_pct, 16'h0000);
    lvl(0, 12'hA00);
    look(10);
    chk(line_speed_pct, 16'h2710);
    lvl(0, 12'h500);
    wr(8'h04, 32'h5);
    look(10);
    chk(tension_setpoint_pct, 16'h1388);
    // Failed capture with the interrupt masked, then unmasked
    wr(8'h38, 32'h0);
    cal(1, 12'h800, 12'h200, DISP_CAL_FAULT);
    rdc(8'h40, 32'h0FFF0000);
    rdc(8'h34, 32'h2);
    rdc(8'h1C, 32'h01200200);
    chk(irq, 1'b0);
    wr(8'h38, 32'h3);
    look(3);
    chk(irq, 1'b1);
    wr(8'h34, 32'h3);
    cal(1, 12'h200, 12'hA00, DISP_NONE);
    lvl(1, 12'h400);
    look(10);
    chk(diameter_signal_pct, 16'h09C4);
    chk(diameter_value, 16'h0145);
    wr(8'h08, 32'h2710);
    wr(8'h0C, 32'h0);
    look(10);
    chk(diameter_signal_pct, 16'h1D4C);
    chk(diameter_value, 16'h0307);
    // Frequency capture, then twice the rate so the line percent clamps
    cal(2, 12'h000, 12'h002, DISP_NONE);
    rdc(8'h44, 32'h00190000);
    lvl(2, 12'h001);
    wr(8'h04, 32'h8);
    look(300);
    chk(line_speed_pct, 16'h2710);
    chk(roll_speed_pct, 16'h09C4);
    wr(8'h04, 32'h9);
    look(10);
    chk(line_speed_pct, 16'h09C4);
    chk(roll_speed_pct, 16'h2710);
    lvl(2, 12'h000);
    look(300);
    chk(roll_speed_pct, 16'h0000);
    wr(8'h18, 32'h3000);
    wr(8'h04, 32'hA);
    look(10);
    chk(line_speed_pct, 16'h1388);
    chk(roll_speed_pct, 16'h09C4);
    chk(tension_setpoint_pct, 16'h2710);
    // Reset in mid-run brings the calibration points back
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(8'h3C, 32'h0FFF0000);
    summarize();
  end
endmodule

bind input_calibration_sequencer cal_seq_monitor #(.PROMPT_CYCLES(PROMPT_CYCLES))
  cal_seq_monitor_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .display_mode(display_mode),
  .line_speed_pct(line_speed_pct), .tension_setpoint_pct(tension_setpoint_pct),
  .diameter_signal_pct(diameter_signal_pct), .roll_speed_pct(roll_speed_pct));
